// ===== shared/rdt_pkg.sv
// Package for the run direction terminal decoder: function codes, widths, timing.
// Assumes a single 50 MHz clock domain.
package rdt_pkg;
  localparam int unsigned N_TERM        = 5;
  localparam int unsigned CODE_W        = 7;
  localparam logic [6:0]  FN_FORWARD    = 7'h00;
  localparam logic [6:0]  FN_REVERSE    = 7'h01;
  // Output terminal function codes
  localparam logic [6:0]  OUT_RUN       = 7'h00;
  localparam logic [6:0]  OUT_ARR_CONST = 7'h01;
  localparam logic [6:0]  OUT_ARR_OVER  = 7'h02;
  localparam logic [6:0]  OUT_OVERLOAD  = 7'h03;
  localparam logic [6:0]  OUT_PID_DEV   = 7'h04;
  localparam logic [6:0]  OUT_ALARM     = 7'h05;
  localparam logic [6:0]  OUT_ANA_DISC  = 7'h06;
  localparam logic [6:0]  OUT_PID_2ND   = 7'h07;
  localparam logic [6:0]  OUT_NET_DET   = 7'h08;
  localparam logic [6:0]  OUT_LOGIC     = 7'h09;
  localparam logic [6:0]  OUT_NET_ERR   = 7'h0A;
  localparam logic [6:0]  OUT_LOW_LOAD  = 7'h2B;
  localparam int unsigned OUT_N         = 12;
  // Debounce time and derived cycles at 50 MHz
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned DEBOUNCE_US   = 2;
  localparam int unsigned DEBOUNCE_CYC  = (DEBOUNCE_US * (CLK_HZ / 1_000_000));
  localparam int unsigned DB_CNT_W      = 8;
  typedef enum logic [1:0] {RDT_STOP = 2'b00, RDT_FWD = 2'b01, RDT_REV = 2'b10} rdt_dir_e;
endpackage

// ===== hw/rdt_debounce.sv
// One input terminal: two-flop synchroniser, then a stable-count debouncer.
// Assumes the terminal level is already a logic level at the pin.
`timescale 1ns/1ps
module rdt_debounce #(
  parameter int unsigned CYCLES = 100,
  parameter int unsigned CNT_W  = 8
) (
  input  wire logic clk,   // 50 MHz clock
  input  wire logic rstn,  // Async reset, active low
  input  wire logic din,   // Raw terminal level
  output logic      dout   // Debounced level
);
  logic             s1_q, s2_q, s1_d, s2_d;
  logic             out_q, out_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;

  always_comb
  begin
    s1_d  = din;
    s2_d  = s1_q;
    out_d = out_q;
    cnt_d = '0;
    if (s2_q != out_q)
    begin
      // New level must hold for the full window before it is accepted
      if (cnt_q == CNT_W'(CYCLES - 1))
        out_d = s2_q;
      else
        cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_q  <= 1'b0;
      s2_q  <= 1'b0;
      out_q <= 1'b0;
      cnt_q <= '0;
    end
    else
    begin
      s1_q  <= s1_d;
      s2_q  <= s2_d;
      out_q <= out_d;
      cnt_q <= cnt_d;
    end
  end

  assign dout = out_q;
endmodule

// ===== hw/rdt_top.sv
// Run direction decode from five programmable input terminals, plus output terminal mux.
// Assumes terminals are static-level sources; configuration ports held stable by firmware.
//
// Function
// RQ1 - Five identical input terminals each take any function via their own select.
// RQ2 - A terminal coded forward runs the motor forward while asserted and stops it when released.
// RQ3 - A terminal coded reverse runs the motor in reverse while asserted and stops it when released.
// RQ4 - Forward and reverse asserted together give stop.
// RQ5 - A normally-closed run terminal counts as asserted when it has no voltage; with sink_logic set the code asserts it when the pin is high instead.
// RQ6 - Forward and reverse may be assigned to any of the five terminals.
// RQ7 - The keypad direction setting steers only the keypad run key, never the terminals.
// RQ8 - Run inputs are levels, so a run asserted at power-up starts the motor.
// RQ9 - The outside party activates inputs toward supply for source or toward ground for sink.
// RQ10 - The output terminal select uses the fixed twelve-entry status code map.
// RQ11 - Every terminal is synchronised and debounced before decode.
`timescale 1ns/1ps
module rdt_top
#(
  parameter int unsigned DB_CYCLES = rdt_pkg::DEBOUNCE_CYC
) (
  input  wire logic                                  clk,                        // 50 MHz clock
  input  wire logic                                  rstn,                       // Async reset, active low
  input  wire logic [rdt_pkg::N_TERM-1:0]            term_in,                    // Raw terminal levels, 1 = high
  input  wire logic                                  sink_logic,                 // 1 = sink jumper, 0 = source
  input  wire logic [rdt_pkg::N_TERM-1:0]            term_normally_closed,       // Per-terminal NC option
  input  wire logic [rdt_pkg::N_TERM*rdt_pkg::CODE_W-1:0] input_function_select, // Five 7-bit codes
  input  wire logic                                  run_command_source_param,   // 1 = terminals give run
  input  wire logic                                  keypad_run_direction_param, // 0 = fwd, 1 = rev
  input  wire logic                                  keypad_run_key,             // Keypad run level
  input  wire logic [rdt_pkg::CODE_W-1:0]            output_function_select,     // Output terminal code
  input  wire logic [rdt_pkg::OUT_N-1:0]             status_flags,               // Status in code order
  output logic                                       forward_run_cmd,            // Forward run level
  output logic                                       reverse_run_cmd,            // Reverse run level
  output logic                                       run_conflict,               // Both asserted
  output logic                                       output_terminal,            // Selected status
  output logic                                       output_code_invalid         // Unmapped output code
);
  import rdt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [N_TERM-1:0] clean;
  logic [N_TERM-1:0] active;
  logic              fw_any, rv_any;

  for (genvar i = 0; i < N_TERM; i++)
  begin : g_term
    rdt_debounce #(.CYCLES(DB_CYCLES), .CNT_W(DB_CNT_W)) u_db ( // [RQ1] [RQ11]
      .clk  (clk),
      .rstn (rstn),
      .din  (term_in[i]),
      .dout (clean[i])
    );
  end

  always_comb
  begin
    fw_any = 1'b0;
    rv_any = 1'b0;
    for (int i = 0; i < N_TERM; i++)
    begin
      // Sink: pulled to ground means on; NC inverts again
      active[i] = (clean[i] ^ sink_logic) ^ term_normally_closed[i]; // [RQ5] [RQ9]
      if (input_function_select[i*CODE_W +: CODE_W] == FN_FORWARD && active[i])
        fw_any = 1'b1; // [RQ2] [RQ6]
      if (input_function_select[i*CODE_W +: CODE_W] == FN_REVERSE && active[i])
        rv_any = 1'b1; // [RQ3] [RQ6]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  rdt_dir_e dir_q, dir_d;
  logic     conf_q, conf_d;
  logic     fwd_q, fwd_d, rev_q, rev_d;

  always_comb
  begin
    conf_d = 1'b0;
    dir_d  = RDT_STOP;
    if (run_command_source_param)
    begin
      // Pure level decode, no start edge needed, so a held run at power-up runs
      case ({fw_any, rv_any}) // [RQ8]
        2'b10:   dir_d = RDT_FWD;   // [RQ2]
        2'b01:   dir_d = RDT_REV;   // [RQ3]
        2'b11:
        begin
          dir_d  = RDT_STOP;        // [RQ4]
          conf_d = 1'b1;
        end
        default: dir_d = RDT_STOP;
      endcase
    end
    else if (keypad_run_key)
      dir_d = keypad_run_direction_param ? RDT_REV : RDT_FWD; // [RQ7]
    // Decoded ahead of the flops so the pins leave straight from registers
    fwd_d = (dir_d == RDT_FWD);
    rev_d = (dir_d == RDT_REV);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dir_q  <= RDT_STOP;
      conf_q <= 1'b0;
      fwd_q  <= 1'b0;
      rev_q  <= 1'b0;
    end
    else
    begin
      dir_q  <= dir_d;
      conf_q <= conf_d;
      fwd_q  <= fwd_d;
      rev_q  <= rev_d;
    end
  end

  assign forward_run_cmd = fwd_q;
  assign reverse_run_cmd = rev_q;
  assign run_conflict    = conf_q;

  ////////////////////////////////////////////////////////////////////////////
  logic out_q, out_d, inv_q, inv_d;

  always_comb
  begin
    inv_d = 1'b0;
    case (output_function_select) // [RQ10]
      OUT_RUN:       out_d = status_flags[0];
      OUT_ARR_CONST: out_d = status_flags[1];
      OUT_ARR_OVER:  out_d = status_flags[2];
      OUT_OVERLOAD:  out_d = status_flags[3];
      OUT_PID_DEV:   out_d = status_flags[4];
      OUT_ALARM:     out_d = status_flags[5];
      OUT_ANA_DISC:  out_d = status_flags[6];
      OUT_PID_2ND:   out_d = status_flags[7];
      OUT_NET_DET:   out_d = status_flags[8];
      OUT_LOGIC:     out_d = status_flags[9];
      OUT_NET_ERR:   out_d = status_flags[10];
      OUT_LOW_LOAD:  out_d = status_flags[11];
      default:
      begin
        out_d = 1'b0;
        inv_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      out_q <= 1'b0;
      inv_q <= 1'b0;
    end
    else
    begin
      out_q <= out_d;
      inv_q <= inv_d;
    end
  end

  assign output_terminal     = out_q;
  assign output_code_invalid = inv_q;

  ////////////////////////////////////////////////////////////////////////////
  a_no_both_dirs: assert property (@(posedge clk) disable iff (!rstn) // [RQ4]
    !(forward_run_cmd && reverse_run_cmd)) else $error("both directions driven");
  a_conflict_stops: assert property (@(posedge clk) disable iff (!rstn) // [RQ4]
    (run_command_source_param && fw_any && rv_any) |=> (!forward_run_cmd && !reverse_run_cmd && run_conflict))
    else $error("conflict did not stop");
  a_fwd_follows: assert property (@(posedge clk) disable iff (!rstn) // [RQ2]
    (run_command_source_param && fw_any && !rv_any) |=> forward_run_cmd) else $error("forward not run");
  a_rev_follows: assert property (@(posedge clk) disable iff (!rstn) // [RQ3]
    (run_command_source_param && rv_any && !fw_any) |=> reverse_run_cmd) else $error("reverse not run");
  a_release_stops: assert property (@(posedge clk) disable iff (!rstn) // [RQ2]
    (run_command_source_param && !fw_any && !rv_any) |=> (!forward_run_cmd && !reverse_run_cmd))
    else $error("release did not stop");
  a_keypad_no_term: assert property (@(posedge clk) disable iff (!rstn) // [RQ7]
    (run_command_source_param && $past(run_command_source_param) && $changed(keypad_run_direction_param)
      && $stable(fw_any) && $stable(rv_any))
      |=> $stable(dir_q)) else $error("keypad direction leaked to terminals");
  a_nc_open_runs: assert property (@(posedge clk) disable iff (!rstn) // [RQ5]
    (run_command_source_param && term_normally_closed[0] && !sink_logic && !clean[0]
      && input_function_select[CODE_W-1:0] == FN_FORWARD && !rv_any) |=> forward_run_cmd)
    else $error("nc open not running");
  a_out_mux_alarm: assert property (@(posedge clk) disable iff (!rstn) // [RQ10]
    (output_function_select == OUT_ALARM) |=> (output_terminal == $past(status_flags[5])))
    else $error("alarm code misrouted");
  a_out_mux_lowload: assert property (@(posedge clk) disable iff (!rstn) // [RQ10]
    (output_function_select == OUT_LOW_LOAD) |=> (output_terminal == $past(status_flags[11])))
    else $error("low load code misrouted");
endmodule

// ===== bench/rdt_switch_model.sv
// Field switches or controller driving the five input terminals.
// Assumes the jumper setting is shared with the decoder's sink_logic port.
`timescale 1ns/1ps
module rdt_switch_model
(
  input  wire logic [rdt_pkg::N_TERM-1:0] contact_on, // Contact closed
  input  wire logic                       sink_logic, // Jumper, 1 = sink
  output logic      [rdt_pkg::N_TERM-1:0] term_pin    // Pin voltage, 1 = high
);
  import rdt_pkg::*;

  // Closed contact pulls to ground in sink wiring, to supply in source wiring
  assign term_pin = contact_on ^ {rdt_pkg::N_TERM{sink_logic}};
endmodule

// ===== bench/tb_run_direction_terminal_decode.sv
// Testbench for the run direction decoder: random settings against a reference model.
// Assumes a short debounce count, so every change settles within a few cycles.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin num_errors++; \
  $display("MISMATCH %s exp %0h got %0h", nm, ex, gt); end end
module tb_run_direction_terminal_decode;
  import rdt_pkg::*;
  localparam int unsigned DB     = 4;
  localparam int unsigned SETTLE = DB + 8;
  logic        clk, rstn, sink, src, kdir, kkey;
  logic [4:0]  on, nc, term_in;
  logic [34:0] fsel;
  logic [6:0]  osel;
  logic [11:0] stat;
  logic        fwd, rev, conf, oterm, oinv;
  int          num_errors   = 0;
  int          total_checks = 0;
  logic [6:0]  omap [12] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07, 7'h08, 7'h09, 7'h0A, 7'h2B};

  rdt_switch_model i_rdt_switch_model (.contact_on(on), .sink_logic(sink), .term_pin(term_in));
  rdt_top #(.DB_CYCLES(DB)) i_rdt_top (
    .clk(clk), .rstn(rstn), .term_in(term_in), .sink_logic(sink), .term_normally_closed(nc),
    .input_function_select(fsel), .run_command_source_param(src), .keypad_run_direction_param(kdir),
    .keypad_run_key(kkey), .output_function_select(osel), .status_flags(stat),
    .forward_run_cmd(fwd), .reverse_run_cmd(rev), .run_conflict(conf),
    .output_terminal(oterm), .output_code_invalid(oinv));

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Reference: closed contact XOR NC option gives the asserted level
  task automatic check_all();
    logic f, r, c;
    int   idx;
    f = 1'b0;
    r = 1'b0;
    idx = -1;
    for (int i = 0; i < 5; i++)
    begin
      if (fsel[7*i +: 7] == 7'h00) f |= on[i] ^ nc[i];
      if (fsel[7*i +: 7] == 7'h01) r |= on[i] ^ nc[i];
    end
    for (int k = 0; k < 12; k++)
    begin
      if (omap[k] == osel) idx = k;
    end
    c = src & f & r;
    if (!src)
    begin
      f = kkey & ~kdir;
      r = kkey & kdir;
    end
    `CHK("forward", f & ~r, fwd)
    `CHK("reverse", r & ~f, rev)
    `CHK("conflict", c, conf)
    `CHK("out_term", (idx >= 0) ? stat[idx] : 1'b0, oterm)
    `CHK("out_inv", (idx < 0) ? 1'b1 : 1'b0, oinv)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    #400000;
    num_errors++;
    close_out();
  end

  initial
  begin
    rstn = 1'b0;
    on   = 5'h01;
    nc   = 5'h00;
    sink = 1'b0;
    src  = 1'b1;
    kdir = 1'b0;
    kkey = 1'b0;
    fsel = {5{7'h7F}};
    fsel[6:0] = 7'h00;
    osel = 7'h00;
    stat = 12'h000;
    void'($urandom(80087));
    repeat (12) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    // Run already closed at power-up still starts the motor
    repeat (SETTLE) @(negedge clk);
    `CHK("powerup", 1'b1, fwd)
    on = 5'h00;
    repeat (SETTLE) @(negedge clk);
    // A pulse shorter than the debounce count must never reach the outputs
    on = 5'h01;
    repeat (DB - 2) @(negedge clk);
    on = 5'h00;
    repeat (SETTLE) @(negedge clk)
    begin
      `CHK("glitch", 1'b0, fwd)
    end
    // Random mix of codes on every terminal, NC, wiring and keypad settings
    repeat (300)
    begin
      on   = 5'($urandom);
      nc   = 5'($urandom);
      sink = 1'($urandom);
      src  = ($urandom % 4) != 0;
      kdir = 1'($urandom);
      kkey = 1'($urandom);
      stat = 12'($urandom);
      for (int i = 0; i < 5; i++)
        fsel[7*i +: 7] = (($urandom % 3) == 0) ? 7'($urandom) : 7'($urandom % 2);
      osel = (($urandom % 4) == 0) ? 7'($urandom) : omap[$urandom % 12];
      repeat (SETTLE) @(negedge clk);
      check_all();
      @(negedge clk);
    end
    close_out();
  end
endmodule
